// ==== eetb_pkg.sv ====
package eetb_pkg;
   localparam int unsigned NUM_ARRAYS = 2;
   localparam logic [15:0] ADDR_CONFIG2 = 16'hfe09;
   localparam logic [15:0] ADDR_DIVH_BACKUP_1 = 16'hfe10;
   localparam logic [15:0] ADDR_DIVL_BACKUP_1 = 16'hfe11;
   localparam logic [15:0] ADDR_DIVH_1 = 16'hfe1a;
   localparam logic [15:0] ADDR_DIVL_1 = 16'hfe1b;
   localparam logic [15:0] ADDR_CTRL_1 = 16'hfe1d;
   localparam logic [15:0] ADDR_DIVH_BACKUP_2 = 16'hff70;
   localparam logic [15:0] ADDR_DIVL_BACKUP_2 = 16'hff71;
   localparam logic [15:0] ADDR_DIVH_2 = 16'hff7a;
   localparam logic [15:0] ADDR_DIVL_2 = 16'hff7b;
   localparam logic [15:0] ADDR_CTRL_2 = 16'hff7d;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'hfe12;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'hfe13;
   localparam int unsigned CFG_CLKSEL_BIT = 7;
   localparam int unsigned CFG_REV_BIT = 3;
   localparam int unsigned CTRL_LEGACY_CLK_BIT = 7;
   localparam int unsigned CTRL_ERASE_BIT = 2;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam int unsigned CTRL_PGM_BIT = 0;
   localparam int unsigned DIV_HIGH_BITS = 3;
   localparam logic [7:0] CONFIG2_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h07;
   localparam logic [7:0] BACKUP_RESET = 8'hff;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Arbitrary revision value for this silicon
   localparam logic REV_ID_DEFAULT = 1'b1;
   localparam int unsigned PGM_TICKS = 10;
   localparam int unsigned ERASE_TICKS = 10;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eetb_bus_t;
   typedef struct packed {
      logic [DIV_HIGH_BITS-1:0] high;
      logic [7:0] low;
   } eetb_div_t;
endpackage

// ==== eetb_top.sv ====
// Functional notes
// - Config-two bit 7 picks the clock feeding the time-base divider.
// - Each array has its own 11-bit prescale, high and low registers.
// - Divider registers reload from nonvolatile backups at every reset; here reset also returns the backups to BACKUP_RESET.
// - Control bit 7 has no function and reads zero.
// - Control bit 1 enables automatic program and erase timing.
// - In automatic mode hardware times the operation and clears program-enable.
// - Config-two bit 3 is fixed and reads the silicon revision.
// - EEPROM bits read 0 when programmed, 1 when erased.
//
// Chosen here: the strobed register port.
module eetb_top (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire eetb_pkg::eetb_bus_t BUS,
   input wire logic REF_CLK_A,
   input wire logic REF_CLK_B,
   output logic [7:0] RDATA,
   output logic [eetb_pkg::NUM_ARRAYS-1:0] HV_ENABLE,
   output logic [eetb_pkg::NUM_ARRAYS-1:0] HV_ERASE,
   output logic IRQ
);
   import eetb_pkg::*;

   logic [7:0] config_reg, config_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [7:0] irq_status_reg, irq_status_next;
   logic [7:0] irq_mask_reg, irq_mask_next;
   logic irq_reg, irq_next;
   logic [2:0] ref_sync_reg, ref_sync_next;
   logic ref_edge;
   logic ref_sel;
   logic [NUM_ARRAYS-1:0] done_pulse;
   logic [NUM_ARRAYS-1:0] hv_en_w, hv_er_w;
   logic [7:0] arr_rdata [NUM_ARRAYS];
   logic [NUM_ARRAYS-1:0] arr_hit;

   function automatic logic [15:0] arr_addr(input int unsigned idx, input int unsigned kind);
      logic [15:0] a;
      a = 16'h0000;
      unique case (kind)
         0: a = (idx == 0) ? ADDR_DIVH_1 : ADDR_DIVH_2;
         1: a = (idx == 0) ? ADDR_DIVL_1 : ADDR_DIVL_2;
         2: a = (idx == 0) ? ADDR_CTRL_1 : ADDR_CTRL_2;
         3: a = (idx == 0) ? ADDR_DIVH_BACKUP_1 : ADDR_DIVH_BACKUP_2;
         default: a = (idx == 0) ? ADDR_DIVL_BACKUP_1 : ADDR_DIVL_BACKUP_2;
      endcase
      return a;
   endfunction

   function automatic logic bus_wr_at(input eetb_bus_t b, input logic [15:0] a);
      return b.wr && b.addr == a;
   endfunction

   // Erase and program may need different lengths, so the limit follows bit 2
   function automatic logic [7:0] op_last_tick(input logic erase);
      return 8'((erase ? ERASE_TICKS : PGM_TICKS) - 1);
   endfunction

   // Reference select, then a two-flop sync plus a third flop for edge detect
   // Switching the select mid-phase can add or drop one divider count
   assign ref_sel = config_reg[CFG_CLKSEL_BIT] ? REF_CLK_B : REF_CLK_A;

   always_comb begin
      ref_sync_next = {ref_sync_reg[1:0], ref_sel};
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ref_sync_reg <= 3'b000;
      end else begin
         ref_sync_reg <= ref_sync_next;
      end
   end
   assign ref_edge = ref_sync_reg[1] & ~ref_sync_reg[2];

   always_comb begin
      config_next = config_reg;
      if (bus_wr_at(BUS, ADDR_CONFIG2)) begin
         config_next = BUS.wdata;
         // Revision bit is hard set in silicon, so the written value is dropped
         config_next[CFG_REV_BIT] = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         config_reg <= CONFIG2_RESET;
      end else begin
         config_reg <= config_next;
      end
   end

   // Status bits are sticky until software writes a one to them
   always_comb begin
      irq_mask_next = irq_mask_reg;
      irq_status_next = irq_status_reg;
      if (bus_wr_at(BUS, ADDR_IRQ_MASK)) begin
         irq_mask_next = {6'h00, BUS.wdata[NUM_ARRAYS-1:0]};
      end
      if (bus_wr_at(BUS, ADDR_IRQ_STATUS)) begin
         irq_status_next = irq_status_reg & ~BUS.wdata;
      end
      // Set beats clear in the same cycle
      irq_status_next[NUM_ARRAYS-1:0] = irq_status_next[NUM_ARRAYS-1:0] | done_pulse;
      irq_next = |(irq_status_next & irq_mask_next);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
         irq_reg <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg <= irq_next;
      end
   end

   // Unmapped reads return zero
   always_comb begin
      rdata_next = 8'h00;
      if (BUS.rd) begin
         if (BUS.addr == ADDR_CONFIG2) begin
            rdata_next = config_reg;
            rdata_next[CFG_REV_BIT] = REV_ID_DEFAULT;
         end else if (BUS.addr == ADDR_IRQ_STATUS) begin
            rdata_next = irq_status_reg;
         end else if (BUS.addr == ADDR_IRQ_MASK) begin
            rdata_next = irq_mask_reg;
         end else begin
            for (int i = 0; i < NUM_ARRAYS; i++) begin
               if (arr_hit[i]) begin
                  rdata_next = arr_rdata[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_ARRAYS; g++) begin : g_arr
         typedef enum logic [1:0] {
            ST_IDLE = 2'b00,
            ST_RUN = 2'b01,
            ST_WAIT_SW = 2'b10
         } eetb_state_t;
         eetb_state_t state_reg, state_next;
         eetb_div_t div_reg, div_next;
         eetb_div_t backup_reg, backup_next;
         logic [7:0] ctrl_reg, ctrl_next;
         logic [10:0] pre_cnt_reg, pre_cnt_next;
         logic [7:0] tick_cnt_reg, tick_cnt_next;
         logic load_reg, load_next;
         logic tick;
         logic done;
         logic hit_h, hit_l, hit_c, hit_bh, hit_bl;

         assign hit_h = BUS.addr == arr_addr(g, 0);
         assign hit_l = BUS.addr == arr_addr(g, 1);
         assign hit_c = BUS.addr == arr_addr(g, 2);
         assign hit_bh = BUS.addr == arr_addr(g, 3);
         assign hit_bl = BUS.addr == arr_addr(g, 4);
         assign arr_hit[g] = hit_h | hit_l | hit_c | hit_bh | hit_bl;
         // Compare with >= so a prescale lowered below the running count
         // takes effect at once instead of after a full 11-bit wrap
         assign tick = ref_edge && (pre_cnt_reg >= {div_reg.high, div_reg.low});
         assign done_pulse[g] = done;
         assign hv_en_w[g] = state_reg != ST_IDLE && ctrl_reg[CTRL_PGM_BIT];
         assign hv_er_w[g] = ctrl_reg[CTRL_ERASE_BIT];

         always_comb begin
            arr_rdata[g] = 8'h00;
            if (hit_h) begin
               arr_rdata[g] = {5'h00, div_reg.high};
            end else if (hit_l) begin
               arr_rdata[g] = div_reg.low;
            end else if (hit_c) begin
               arr_rdata[g] = {1'b0, ctrl_reg[6:0]};
            end else if (hit_bh) begin
               arr_rdata[g] = {5'h00, backup_reg.high};
            end else if (hit_bl) begin
               arr_rdata[g] = backup_reg.low;
            end
         end

         always_comb begin
            div_next = div_reg;
            backup_next = backup_reg;
            ctrl_next = ctrl_reg;
            state_next = state_reg;
            pre_cnt_next = pre_cnt_reg;
            tick_cnt_next = tick_cnt_reg;
            load_next = 1'b0;
            done = 1'b0;
            // First cycle after reset copies the backups into the volatile divider
            if (load_reg) begin
               div_next = backup_reg;
            end
            if (BUS.wr && hit_h) begin
               div_next.high = BUS.wdata[DIV_HIGH_BITS-1:0];
            end
            if (BUS.wr && hit_l) begin
               div_next.low = BUS.wdata;
            end
            if (BUS.wr && hit_bh) begin
               backup_next.high = BUS.wdata[DIV_HIGH_BITS-1:0];
            end
            if (BUS.wr && hit_bl) begin
               backup_next.low = BUS.wdata;
            end
            if (BUS.wr && hit_c) begin
               ctrl_next = BUS.wdata & CTRL_WRITE_MASK;
            end
            if (ref_edge) begin
               pre_cnt_next = tick ? 11'h000 : pre_cnt_reg + 11'h001;
            end
            unique case (state_reg)
               ST_IDLE: begin
                  if (ctrl_next[CTRL_PGM_BIT]) begin
                     // Tick count restarts, but the free-running prescale can make the first tick short
                     tick_cnt_next = 8'h00;
                     state_next = ctrl_next[CTRL_AUTO_BIT] ? ST_RUN : ST_WAIT_SW;
                  end
               end
               ST_RUN: begin
                  if (tick) begin
                     tick_cnt_next = tick_cnt_reg + 8'h01;
                  end
                  if (tick && tick_cnt_reg == op_last_tick(ctrl_reg[CTRL_ERASE_BIT])) begin
                     ctrl_next[CTRL_PGM_BIT] = 1'b0;
                     state_next = ST_IDLE;
                     done = 1'b1;
                  end else if (!ctrl_next[CTRL_PGM_BIT]) begin
                     state_next = ST_IDLE;
                  end
               end
               ST_WAIT_SW: begin
                  // Software owns the timing here
                  if (!ctrl_next[CTRL_PGM_BIT]) begin
                     state_next = ST_IDLE;
                     done = 1'b1;
                  end
               end
               default: state_next = ST_IDLE;
            endcase
         end

         always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
               state_reg <= ST_IDLE;
               div_reg <= '0;
               backup_reg <= {BACKUP_RESET[DIV_HIGH_BITS-1:0], BACKUP_RESET};
               ctrl_reg <= CTRL_RESET;
               pre_cnt_reg <= 11'h000;
               tick_cnt_reg <= 8'h00;
               load_reg <= 1'b1;
            end else begin
               state_reg <= state_next;
               div_reg <= div_next;
               backup_reg <= backup_next;
               ctrl_reg <= ctrl_next;
               pre_cnt_reg <= pre_cnt_next;
               tick_cnt_reg <= tick_cnt_next;
               load_reg <= load_next;
            end
         end
      end
   endgenerate

   // Programmed cells read 0, erased read 1; array data path lives outside
   logic [NUM_ARRAYS-1:0] hv_en_reg, hv_en_next, hv_er_reg, hv_er_next;

   // Registered so decode glitches never reach the high-voltage controls
   always_comb begin
      hv_en_next = hv_en_w;
      hv_er_next = hv_er_w;
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         hv_en_reg <= '0;
         hv_er_reg <= '0;
      end else begin
         hv_en_reg <= hv_en_next;
         hv_er_reg <= hv_er_next;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = irq_reg;
   assign HV_ENABLE = hv_en_reg;
   assign HV_ERASE = hv_er_reg;
endmodule

// ==== eetb_chk_monitor.sv ====
module eetb_chk_monitor
   import eetb_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire eetb_pkg::eetb_bus_t BUS,
   input wire logic [7:0] RDATA,
   input wire logic [1:0] HV_ENABLE,
   input wire logic [1:0] HV_ERASE,
   input wire logic IRQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence rd_at(logic [15:0] a);
      BUS.rd && BUS.addr == a;
   endsequence
   sequence wr_at(logic [15:0] a);
      BUS.wr && BUS.addr == a;
   endsequence
   sequence auto_go;
      wr_at(ADDR_CTRL_1) ##0 BUS.wdata == 8'h03;
   endsequence
   sequence manual_go;
      wr_at(ADDR_CTRL_2) ##0 BUS.wdata == 8'h01;
   endsequence
   sequence manual_stop;
      wr_at(ADDR_CTRL_2) ##0 BUS.wdata == 8'h00;
   endsequence
   rdata_idle_a: assert property (!BUS.rd |=> RDATA == 8'h00)
      else $error("read data not idle");
   rev_bit_a: assert property (rd_at(ADDR_CONFIG2) |=> RDATA[3] == REV_ID_DEFAULT)
      else $error("revision bit wrong");
   ctrl_upper_a: assert property (rd_at(ADDR_CTRL_1) |=> RDATA[7:3] == 5'h00)
      else $error("control upper bits not zero");
   erase_sel_a: assert property (wr_at(ADDR_CTRL_1) |-> ##2 HV_ERASE[0] == $past(BUS.wdata[2], 2))
      else $error("erase select not followed");
   auto_hold_a: assert property (auto_go |-> ##2 HV_ENABLE[0] [*8])
      else $error("auto operation ended early");
   auto_done_a: assert property (auto_go |-> ##[20:1000] !HV_ENABLE[0])
      else $error("auto operation never ended");
   mask_off_a: assert property (wr_at(ADDR_IRQ_MASK) ##0 BUS.wdata == 8'h00 |-> ##2 !IRQ)
      else $error("interrupt not masked");
   manual_hold_a: assert property (manual_go |-> ##2 HV_ENABLE[1] [*8])
      else $error("manual operation dropped");
   manual_end_a: assert property (manual_stop |-> ##2 !HV_ENABLE[1])
      else $error("manual operation not released");
endmodule

bind eetb_top eetb_chk_monitor u_mon(.CORE_CLK(CORE_CLK), .RST(RST), .BUS(BUS), .RDATA(RDATA),
   .HV_ENABLE(HV_ENABLE), .HV_ERASE(HV_ERASE), .IRQ(IRQ));

// ==== tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import eetb_pkg::*;
   logic CORE_CLK = 1'b0;
   logic RST = 1'b1;
   eetb_bus_t bus = '0;
   logic ref_a = 1'b0, ref_b = 1'b0, b_run = 1'b0, rd_d = 1'b0;
   logic [7:0] rdata, last_rd;
   logic [1:0] hv_en, hv_er;
   logic irq;
   logic [15:0] expq[$];
   int miscompares = 0, n_tests = 0, cycles = 0;
   always #12.5 CORE_CLK = ~CORE_CLK;
   eetb_top u_eetb_top(.CORE_CLK(CORE_CLK), .RST(RST), .BUS(bus), .REF_CLK_A(ref_a),
      .REF_CLK_B(ref_b), .RDATA(rdata), .HV_ENABLE(hv_en), .HV_ERASE(hv_er), .IRQ(irq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      n_tests++;
      if ((got & m) !== (exp & m)) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CORE_CLK);
      bus.wr <= 1'b0;
   endtask
   // Mask zero means the read is a poll with no note queued
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge CORE_CLK);
      if (m != 8'h00) expq.push_back({m, e});
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge CORE_CLK);
      bus.rd <= 1'b0;
   endtask
   task automatic poll(input logic [15:0] a);
      for (int k = 0; k < 400; k++) begin
         rd(a, 8'h00, 8'h00);
         // Data stands one edge after the strobe; let the watcher take it first
         @(posedge CORE_CLK);
         #1;
         if (last_rd[0] === 1'b0) break;
      end
      chk({7'h00, last_rd[0]}, 8'h00, 8'h01);
   endtask
   task automatic pulse_rst();
      @(posedge CORE_CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
   endtask
   always @(posedge CORE_CLK) begin
      logic [15:0] v;
      if (rd_d) begin
         last_rd = rdata;
         if (expq.size() > 0) begin
            v = expq.pop_front();
            chk(rdata, v[7:0], v[15:8]);
         end
      end
      rd_d = bus.rd;
   end
   always @(posedge CORE_CLK) begin
      ref_a <= ~ref_a;
      if (b_run) ref_b <= ~ref_b;
      cycles++;
      // Ceiling well above the longest auto wait plus polls
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] r;
      void'($urandom(32'h7f3f));
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      rd(ADDR_CONFIG2, 8'h08, 8'h88);
      rd(ADDR_DIVH_BACKUP_1, 8'h07, 8'hff);
      rd(ADDR_DIVH_1, 8'h07, 8'h07);
      rd(ADDR_DIVL_2, 8'hff, 8'hff);
      rd(16'hfe14, 8'h00, 8'hff);
      $display("reset image done");
      r = 8'($urandom());
      wr(ADDR_DIVL_1, r);
      wr(ADDR_DIVH_1, r);
      rd(ADDR_DIVL_1, r, 8'hff);
      rd(ADDR_DIVH_1, r, 8'h07);
      pulse_rst();
      rd(ADDR_DIVL_1, 8'hff, 8'hff);
      $display("divider reload done");
      wr(ADDR_CTRL_1, 8'h84);
      rd(ADDR_CTRL_1, 8'h04, 8'hff);
      chk({7'h00, hv_er[0]}, 8'h01, 8'h01);
      wr(ADDR_CTRL_1, 8'h00);
      $display("control bits done");
      // Short prescale keeps an auto run near eighty cycles whenever its selected reference toggles
      wr(ADDR_DIVH_1, 8'h00);
      wr(ADDR_DIVL_1, 8'h03);
      wr(ADDR_DIVH_2, 8'h00);
      wr(ADDR_DIVL_2, 8'h03);
      wr(ADDR_IRQ_MASK, 8'h03);
      wr(ADDR_CONFIG2, 8'h80);
      wr(ADDR_CTRL_1, 8'h03);
      repeat (300) @(posedge CORE_CLK);
      chk({7'h00, hv_en[0]}, 8'h01, 8'h01);
      wr(ADDR_CONFIG2, 8'h00);
      poll(ADDR_CTRL_1);
      rd(ADDR_IRQ_STATUS, 8'h01, 8'h01);
      chk({7'h00, irq}, 8'h01, 8'h01);
      wr(ADDR_IRQ_STATUS, 8'h01);
      repeat (3) @(posedge CORE_CLK);
      chk({7'h00, irq}, 8'h00, 8'h01);
      b_run <= 1'b1;
      wr(ADDR_CONFIG2, 8'h80);
      wr(ADDR_CTRL_2, 8'h07);
      poll(ADDR_CTRL_2);
      rd(ADDR_IRQ_STATUS, 8'h02, 8'h02);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_IRQ_STATUS, 8'h02);
      $display("auto timing done");
      wr(ADDR_CTRL_2, 8'h01);
      repeat (50) @(posedge CORE_CLK);
      chk({7'h00, hv_en[1]}, 8'h01, 8'h01);
      rd(ADDR_CTRL_2, 8'h01, 8'hff);
      wr(ADDR_CTRL_2, 8'h00);
      repeat (3) @(posedge CORE_CLK);
      chk({7'h00, hv_en[1]}, 8'h00, 8'h01);
      rd(ADDR_IRQ_STATUS, 8'h02, 8'h02);
      $display("manual timing done");
      print_verdict();
   end
endmodule
